// >>> rtl/pixel_capture_pkg.sv
package pixel_capture_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int PIXEL_W   = 12;
    localparam int TEN_BIT_W = 10;
    localparam int GAP_W     = 4;
    localparam int PERIOD_W  = 8;
    localparam int FRAME_W   = 10;
    localparam int SYNC_N    = 2;

    // Least number of pixel clocks between two sync toggles in 10-bit mode.
    localparam logic [GAP_W-1:0] SYNC_GAP_CYCLES = 4'hA;

    // Serial bits carried per pixel-clock word slot.
    localparam int SERIAL_BITS_PER_WORD = 28;

    // Reference clock rate and legal pixel clock ranges, in kHz.
    localparam int REF_CLK_KHZ   = 250000;
    localparam int TEN_MIN_KHZ   = 50000;
    localparam int TEN_MAX_KHZ   = 100000;
    localparam int HIGH_MIN_KHZ  = 37500;
    localparam int HIGH_MAX_KHZ  = 75000;
    localparam int LOW_MIN_KHZ   = 25000;
    localparam int LOW_MAX_KHZ   = 50000;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [PIXEL_W-1:0]  PIXEL_RESET  = 12'h000;
    localparam logic [PERIOD_W-1:0] PERIOD_RESET = 8'h00;
    localparam logic [FRAME_W-1:0]  FRAME_RESET  = 10'h000;

    // ------------------------------------------------------------------
    // Payload modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ten_bit_mode,
        high_rate_twelve_bit_mode,
        low_rate_twelve_bit_mode
    } payload_mode_t;

endpackage : pixel_capture_pkg

// >>> rtl/pixel_period_meter.sv
`timescale 1ns/10ps

module pixel_period_meter (
    input  wire logic                                  ref_clk,
    input  wire logic                                  resetn,
    input  wire logic                                  edge_seen,
    output logic [pixel_capture_pkg::PERIOD_W-1:0]     pixel_period
);

    typedef struct packed {
        logic [pixel_capture_pkg::PERIOD_W-1:0] count;
        logic [pixel_capture_pkg::PERIOD_W-1:0] period;
    } meter_state_t;

    meter_state_t state;
    meter_state_t next_state;

    // Counts saturate at 8'hFE so the first edge after a stopped pixel clock gives the largest period.
    always_comb begin
        next_state = state;
        if (edge_seen) begin
            next_state.period = state.count + 8'h01;
            next_state.count  = pixel_capture_pkg::PERIOD_RESET;
        end else if (state.count != 8'hFE) begin
            next_state.count = state.count + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pixel_period = state.period;

endmodule : pixel_period_meter

// >>> rtl/parallel_pixel_input_capture.sv
`timescale 1ns/10ps

// Behaviour
// - Ten-bit mode captures data bits 9..0 only, upper two read zero.
// - Both twelve-bit modes capture all twelve data bits each sampled edge.
// - Twelve-bit modes pass syncs raw each pixel clock with no toggle limit.
// - Strobe edge select input picks the pixel clock edge used for sampling.
// - Serial word slot spans one, one and a half, or two pixel periods.
module parallel_pixel_input_capture (
    input  wire logic                                  ref_clk,
    input  wire logic                                  resetn,
    input  wire logic [1:0]                            payload_mode,
    input  wire logic                                  strobe_edge_select,
    input  wire logic                                  pixel_clk,
    input  wire logic [pixel_capture_pkg::PIXEL_W-1:0] pixel_data_in,
    input  wire logic                                  line_sync_in,
    input  wire logic                                  frame_sync_in,
    output logic [pixel_capture_pkg::PIXEL_W-1:0]      pixel_data,
    output logic                                       line_sync,
    output logic                                       frame_sync,
    output logic                                       pixel_valid,
    output logic                                       sync_rule_error,
    output logic [pixel_capture_pkg::FRAME_W-1:0]      serial_frame_cycles
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                                                           pclk_q;
        logic [pixel_capture_pkg::PIXEL_W-1:0]                          data;
        logic [pixel_capture_pkg::SYNC_N-1:0]                           sync;
        logic                                                           valid;
        logic                                                           err;
        logic [pixel_capture_pkg::SYNC_N-1:0][pixel_capture_pkg::GAP_W-1:0] gap;
        logic [pixel_capture_pkg::FRAME_W-1:0]                          frame_cycles;
    } capture_state_t;

    capture_state_t                          state;
    capture_state_t                          next_state;
    pixel_capture_pkg::payload_mode_t        mode;
    logic                                    strobe_hit;
    logic [pixel_capture_pkg::PERIOD_W-1:0]  pixel_period;
    logic [pixel_capture_pkg::SYNC_N-1:0]    sync_in;
    logic [pixel_capture_pkg::FRAME_W-1:0]   period_ext;

    // Encoding 3 is unused; it falls back to the low-rate twelve-bit mode.
    assign mode = (payload_mode == 2'h0) ? pixel_capture_pkg::ten_bit_mode :
                  (payload_mode == 2'h1) ? pixel_capture_pkg::high_rate_twelve_bit_mode :
                                           pixel_capture_pkg::low_rate_twelve_bit_mode;

    // A high select samples on the rising edge, a low select on the falling edge.
    assign strobe_hit = (pixel_clk != state.pclk_q) && (pixel_clk == strobe_edge_select);
    assign sync_in    = {frame_sync_in, line_sync_in};
    assign period_ext = {2'h0, pixel_period};

    // ------------------------------------------------------------------
    // Pixel clock period measurement
    // ------------------------------------------------------------------
    pixel_period_meter meter (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .edge_seen    (strobe_hit),
        .pixel_period (pixel_period)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state        = state;
        next_state.pclk_q = pixel_clk;
        next_state.valid  = 1'b0;
        next_state.err    = 1'b0;
        if (strobe_hit) begin
            next_state.valid = 1'b1;
            next_state.sync  = sync_in;
            if (mode == pixel_capture_pkg::ten_bit_mode) begin
                next_state.data = {2'h0, pixel_data_in[pixel_capture_pkg::TEN_BIT_W-1:0]};
            end else begin
                next_state.data = pixel_data_in;
            end
            // The gap counter holds edges since the last toggle; a toggle closes a gap of
            // count plus one pixel clocks.
            for (int i = 0; i < pixel_capture_pkg::SYNC_N; i++) begin
                if (sync_in[i] != state.sync[i]) begin
                    if ((mode == pixel_capture_pkg::ten_bit_mode) &&
                        ((state.gap[i] + 4'h1) < pixel_capture_pkg::SYNC_GAP_CYCLES)) begin
                        next_state.err = 1'b1;
                    end
                    next_state.gap[i] = 4'h0;
                end else if (state.gap[i] != pixel_capture_pkg::SYNC_GAP_CYCLES) begin
                    next_state.gap[i] = state.gap[i] + 4'h1;
                end
            end
        end
        // Reference cycles per serial word slot; one serial bit is a 28th of it.
        case (mode)
            pixel_capture_pkg::ten_bit_mode: begin
                next_state.frame_cycles = {period_ext[pixel_capture_pkg::FRAME_W-2:0],
                                           1'b0};
            end
            pixel_capture_pkg::high_rate_twelve_bit_mode: begin
                next_state.frame_cycles = period_ext +
                                          {1'b0, period_ext[pixel_capture_pkg::FRAME_W-1:1]};
            end
            default: begin
                next_state.frame_cycles = period_ext;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state              <= '0;
            state.gap[0]       <= pixel_capture_pkg::SYNC_GAP_CYCLES;
            state.gap[1]       <= pixel_capture_pkg::SYNC_GAP_CYCLES;
        end else begin
            state <= next_state;
        end
    end

    assign pixel_data          = state.data;
    assign line_sync           = state.sync[0];
    assign frame_sync          = state.sync[1];
    assign pixel_valid         = state.valid;
    assign sync_rule_error     = state.err;
    assign serial_frame_cycles = state.frame_cycles;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence selected_edge_s;
        (pixel_clk != $past(pixel_clk)) && (pixel_clk == strobe_edge_select);
    endsequence

    sequence line_toggle_s;
        selected_edge_s ##0 (line_sync_in != line_sync);
    endsequence

    sequence frame_toggle_s;
        selected_edge_s ##0 (frame_sync_in != frame_sync);
    endsequence

    edge_select_a: assert property (selected_edge_s |=> pixel_valid)
        else $error("selected pixel clock edge did not produce a capture");

    wrong_edge_a: assert property (pixel_valid |->
                                   $past(pixel_clk) == $past(strobe_edge_select))
        else $error("capture on the unselected pixel clock edge");

    // Captures need two pixel clock changes, so back-to-back pulses only follow a select flip.
    valid_pulse_a: assert property (pixel_valid && $stable(strobe_edge_select)
                                    |=> !pixel_valid)
        else $error("capture pulse lasted more than one cycle");

    ten_bit_mask_a: assert property (selected_edge_s ##0 (payload_mode == 2'h0)
                                     |=> pixel_data == {2'h0, $past(pixel_data_in[9:0])})
        else $error("ten-bit capture did not drop the upper data bits");

    twelve_bit_a: assert property (selected_edge_s ##0 (payload_mode != 2'h0)
                                   |=> pixel_data == $past(pixel_data_in))
        else $error("twelve-bit capture lost data bits");

    sync_aligned_a: assert property (pixel_valid |-> line_sync == $past(line_sync_in) &&
                                     frame_sync == $past(frame_sync_in))
        else $error("sync state not sampled with its data word");

    // Between captures the word and its syncs must hold, or a consumer could see a torn pair.
    data_hold_a: assert property (!pixel_valid |-> $stable(pixel_data) &&
                                  $stable(line_sync) && $stable(frame_sync))
        else $error("captured word or sync changed without a capture");

    // ------------------------------------------------------------------
    // Sync spacing checks
    // ------------------------------------------------------------------
    raw_sync_a: assert property ($past(payload_mode) != 2'h0 |-> !sync_rule_error)
        else $error("sync toggle limit applied in a twelve-bit mode");

    twelve_toggle_a: assert property ((payload_mode != 2'h0) ##0 line_toggle_s
                                      |=> (line_sync != $past(line_sync)) && !sync_rule_error)
        else $error("twelve-bit line sync toggle was not passed through");

    fast_toggle_a: assert property ((payload_mode == 2'h0) ##0 selected_edge_s ##0
                                    (line_sync_in != line_sync) ##0 (state.gap[0] < 4'h9)
                                    |=> sync_rule_error)
        else $error("early line sync toggle not flagged");

    frame_toggle_a: assert property ((payload_mode == 2'h0) ##0 frame_toggle_s ##0
                                     (state.gap[1] < 4'h9) |=> sync_rule_error)
        else $error("early frame sync toggle not flagged");

    // A toggle that closes a gap of ten or more pixel clocks is legal and must stay quiet.
    slow_toggle_a: assert property ((payload_mode == 2'h0) ##0 selected_edge_s ##0
                                    ((line_sync_in == line_sync) || (state.gap[0] >= 4'h9)) ##0
                                    ((frame_sync_in == frame_sync) || (state.gap[1] >= 4'h9))
                                    |=> !sync_rule_error)
        else $error("legal sync toggle flagged as too early");

    error_with_valid_a: assert property (sync_rule_error |-> pixel_valid)
        else $error("sync spacing error raised without a capture");

    // ------------------------------------------------------------------
    // Serial word slot checks
    // ------------------------------------------------------------------
    frame_scale_a: assert property ((payload_mode == 2'h0) && $stable(pixel_period)
                                    |=> serial_frame_cycles == {1'b0, $past(pixel_period), 1'b0})
        else $error("ten-bit word slot is not two pixel periods");

    // The slot is floored to whole reference cycles, so odd periods lose half a cycle.
    frame_high_a: assert property ((payload_mode == 2'h1) |=> serial_frame_cycles ==
                                   {2'h0, $past(pixel_period)} + {3'h0, $past(pixel_period[7:1])})
        else $error("high-rate word slot is not one and a half pixel periods");

    frame_low_a: assert property (payload_mode[1] |=>
                                  serial_frame_cycles == {2'h0, $past(pixel_period)})
        else $error("low-rate word slot is not one pixel period");

endmodule : parallel_pixel_input_capture

// >>> testbench/pixel_sensor_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Image sensor on the parallel pixel bus
// ------------------------------------------------------------------
// The clock stands still while run is low, and data and syncs fall to their pulldown level.
// Falling halves carry the inverted word, so a capture on the wrong edge shows at once.
module pixel_sensor_model (
    input  wire logic        ref_clk,
    input  wire logic        run,
    input  wire logic [2:0]  half,
    input  wire logic [1:0]  toggle_sync,
    input  wire logic [11:0] word,
    output logic             pixel_clk,
    output logic [11:0]      pixel_data_in,
    output logic             line_sync_in,
    output logic             frame_sync_in
);
    int          count = 0;
    logic        run_q;
    logic [2:0]  half_q;
    logic [1:0]  toggle_q;
    logic [11:0] word_q;
    initial begin
        pixel_clk = 1'b0;
        pixel_data_in = 12'h000;
        line_sync_in = 1'b0;
        frame_sync_in = 1'b0;
    end
    // Controls are taken at the edge, so a bench change one step later never races the drive.
    always @(posedge ref_clk) begin
        run_q = run;
        half_q = half;
        toggle_q = toggle_sync;
        word_q = word;
        #1;
        if (!run_q) begin
            count = 0;
            pixel_data_in = 12'h000;
            line_sync_in = 1'b0;
            frame_sync_in = 1'b0;
        end else if (count >= half_q - 1) begin
            count = 0;
            pixel_clk = !pixel_clk;
            pixel_data_in = pixel_clk ? word_q : ~word_q;
            if (pixel_clk) begin
                line_sync_in = line_sync_in ^ toggle_q[0];
                frame_sync_in = frame_sync_in ^ toggle_q[1];
            end
        end else begin
            count++;
        end
    end
endmodule : pixel_sensor_model

// >>> testbench/parallel_pixel_input_capture_test.sv
`timescale 1ns/10ps
module parallel_pixel_input_capture_test;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [1:0]  payload_mode = 2'h0;
    logic        strobe_edge_select = 1'b1;
    logic        run = 1'b0;
    logic [2:0]  half = 3'h2;
    logic [1:0]  toggle_sync = 2'h0;
    logic [11:0] word = 12'h000;
    logic        pixel_clk, line_sync_in, frame_sync_in, line_sync, frame_sync;
    logic        pixel_valid, sync_rule_error;
    logic [11:0] pixel_data_in, pixel_data;
    logic [9:0]  serial_frame_cycles;
    int          bad_count = 0;
    int          checks_done = 0;
    int          errors = 0;
    int          cycles = 0;
    always #2 ref_clk = !ref_clk;
    pixel_sensor_model i_sensor (.ref_clk(ref_clk), .run(run), .half(half),
        .toggle_sync(toggle_sync), .word(word), .pixel_clk(pixel_clk),
        .pixel_data_in(pixel_data_in), .line_sync_in(line_sync_in),
        .frame_sync_in(frame_sync_in));
    parallel_pixel_input_capture i_dut (.ref_clk(ref_clk), .resetn(resetn),
        .payload_mode(payload_mode), .strobe_edge_select(strobe_edge_select),
        .pixel_clk(pixel_clk), .pixel_data_in(pixel_data_in), .line_sync_in(line_sync_in),
        .frame_sync_in(frame_sync_in), .pixel_data(pixel_data), .line_sync(line_sync),
        .frame_sync(frame_sync), .pixel_valid(pixel_valid),
        .sync_rule_error(sync_rule_error), .serial_frame_cycles(serial_frame_cycles));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic compare(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : compare
    // Runs the sensor until n words are seen, checking each word and its syncs.
    task automatic capture(input logic [1:0] mode, input logic sel, input logic [1:0] tog,
                           input logic [11:0] w, input logic [11:0] exp, input int n);
        int got;
        int waited;
        got = 0;
        waited = 0;
        payload_mode = mode;
        strobe_edge_select = sel;
        half = (mode == 2'h0) ? 3'h2 : 3'h3;
        toggle_sync = tog;
        word = w;
        run = 1'b1;
        while (got < n && waited < 300) begin
            @(posedge ref_clk);
            #1;
            waited++;
            if (sync_rule_error === 1'b1) errors++;
            if (pixel_valid === 1'b1) begin
                got++;
                compare(pixel_data, exp);
                compare({11'h000, line_sync}, {11'h000, tog[0] & got[0]});
                compare({11'h000, frame_sync}, {11'h000, tog[1] & got[0]});
            end
        end
        compare(12'(got), 12'(n));
        run = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask : capture
    task automatic ten_bit_test();
        capture(2'h0, 1'b1, 2'h0, 12'hFFF, 12'h3FF, 3);
        capture(2'h0, 1'b1, 2'h0, 12'hDA5, 12'h1A5, 3);
        capture(2'h0, 1'b0, 2'h0, 12'h9A5, 12'h25A, 3);
        $display("ten-bit capture done");
    endtask : ten_bit_test
    task automatic twelve_bit_test();
        for (int m = 1; m < 4; m++) begin
            capture(2'(m), 1'b1, 2'h0, 12'hA5C, 12'hA5C, 3);
            capture(2'(m), 1'b0, 2'h0, 12'hA5C, 12'h5A3, 3);
        end
        $display("twelve-bit capture done");
    endtask : twelve_bit_test
    task automatic sync_test();
        for (int m = 0; m < 3; m++) begin
            for (int t = 1; t < 3; t++) begin
                errors = 0;
                capture(2'(m), 1'b1, 2'(t), 12'h3C3, 12'h3C3, 5);
                compare({11'h000, errors > 0}, {11'h000, m == 0});
            end
        end
        $display("sync toggle done");
    endtask : sync_test
    task automatic frame_test();
        logic [11:0] exp [3] = '{12'h008, 12'h009, 12'h006};
        for (int m = 0; m < 3; m++) begin
            capture(2'(m), 1'b1, 2'h0, 12'h123, 12'h123, 4);
            compare({2'h0, serial_frame_cycles}, exp[m]);
        end
        $display("serial word slot done");
    endtask : frame_test
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        ten_bit_test();
        twelve_bit_test();
        sync_test();
        frame_test();
        conclude();
    end
endmodule : parallel_pixel_input_capture_test
